// ==== core/ebswc_pkg.sv ====
/*
  Shared constants and types for the external bus strobe and wait
  control block. Assumes a single 200 MHz system clock.
*/
package ebswc_pkg;

  // Shape of the port.
  localparam int ATTR_N = 4;
  localparam int WAIT_W = 5;

  // Clock rate and the rate limits that apply to it.
  localparam int CLK_FREQ_MHZ = 200;
  localparam int ACK_DIRECT_MAX_MHZ = 100;
  localparam int ROW_STROBE_MAX_MHZ = 100;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS
  } ebswc_state_t;

  // One external access as the core asks for it.
  typedef struct packed {
    logic write;
    logic [ATTR_N-1:0] attr;
    logic [WAIT_W-1:0] waits;
  } ebswc_req_t;

  // Operating mode bits that steer the port.
  typedef struct packed {
    logic prio_off;
    logic ack_sync;
    logic [ATTR_N-1:0] ras_mode;
    logic [ATTR_N-1:0] ras_pol;
  } ebswc_cfg_t;

  // Complete state of the controller.
  typedef struct packed {
    ebswc_state_t state;
    logic [WAIT_W-1:0] cnt;
    logic [WAIT_W-1:0] waits;
    logic write;
    logic prio_off;
    logic [ATTR_N-1:0] attr_act;
    logic ack_meta;
    logic ack_sync;
    logic rd_n;
    logic wr_n;
    logic ctl_oe;
    logic [ATTR_N-1:0] line;
    logic [ATTR_N-1:0] line_oe;
    logic done;
    logic busy;
  } ebswc_regs_t;

  localparam ebswc_regs_t REGS_RST = '{
    state: ST_IDLE,
    cnt: '0,
    waits: '0,
    write: 1'b0,
    prio_off: 1'b0,
    attr_act: '0,
    ack_meta: 1'b1,
    ack_sync: 1'b1,
    rd_n: 1'b1,
    wr_n: 1'b1,
    ctl_oe: 1'b0,
    line: '0,
    line_oe: '0,
    done: 1'b0,
    busy: 1'b0
  };

endpackage

// ==== core/ebswc_core.sv ====
/*
  External bus strobe and wait control: attribute / row strobe lines,
  active-low read and write strobes and transfer-acknowledge stretching.
  Assumes bus ownership and standby come from arbitration and power logic
  elsewhere, and that all inputs are synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
// Overview of operation
// - Default: attribute lines prioritised, at most one active.
// - Priority-off bit drives all four lines independently.
// - Attribute line works as select or address.
// - Row strobe pins idle inactive, polarity chosen by configuration.
// - Owner drives read strobe low; else floats.
// - Owner drives write strobe low; else floats.
// - Acknowledge ignored unless owner with access running.
// - Inactive acknowledge adds wait states without limit.
// - Cycle ends one clock after acknowledge seen.
// - Cycle lasts longer of programmed or acknowledged waits.
// - Acknowledge stretching needs one or more programmed waits.
// - Zero-wait access completes ignoring acknowledge.
// - Mode bit picks direct or synchronised acknowledge sampling.
// - Above 100 MHz acknowledge is always synchronised.
// - Row strobe mode unavailable above 100 MHz.
// - Standby releases bus and floats all port outputs.
module ebswc_core #(
  parameter int CLK_MHZ = ebswc_pkg::CLK_FREQ_MHZ
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Ownership and power state
  input wire logic bus_owner_i,
  input wire logic standby_i,
  // Configuration
  input wire ebswc_pkg::ebswc_cfg_t cfg_i,
  // Access request
  input wire logic req_valid_i,
  input wire ebswc_pkg::ebswc_req_t req_i,
  output logic access_busy_o,
  output logic cycle_done_ack_o,
  // Acknowledge from the partner
  input wire logic transfer_ack_n_i,
  // Attribute or row strobe pins
  output logic [ebswc_pkg::ATTR_N-1:0] attr_select_line_o,
  output logic [ebswc_pkg::ATTR_N-1:0] attr_select_line_oe_o,
  // Read and write strobes
  output logic read_strobe_n_o,
  output logic read_strobe_oe_o,
  output logic write_strobe_n_o,
  output logic write_strobe_oe_o
);

  // Keeps only the lowest set bit, so bit 0 has the highest priority.
  function automatic logic [ebswc_pkg::ATTR_N-1:0] prio_pick(
    input logic [ebswc_pkg::ATTR_N-1:0] v
  );
    logic [ebswc_pkg::ATTR_N-1:0] o;
    o = v & (~v + 1'b1);
    return o;
  endfunction

  // Direct sampling and row strobes both fail timing above the limit.
  localparam logic FAST_ACK = (CLK_MHZ > ebswc_pkg::ACK_DIRECT_MAX_MHZ);
  localparam logic FAST_ROW = (CLK_MHZ > ebswc_pkg::ROW_STROBE_MAX_MHZ);

  ebswc_pkg::ebswc_regs_t r;
  ebswc_pkg::ebswc_regs_t next_r;

  logic link_ok;
  logic eff_sync;
  logic ack_on;
  logic take;
  logic [ebswc_pkg::ATTR_N-1:0] eff_ras;

  assign link_ok = bus_owner_i && !standby_i;
  assign eff_sync = cfg_i.ack_sync || FAST_ACK;
  // Direct mode reads the pin as is; the partner keeps it in step.
  assign ack_on = eff_sync ? !r.ack_sync : !transfer_ack_n_i;
  assign take = req_valid_i && link_ok && (r.state == ebswc_pkg::ST_IDLE);
  assign eff_ras = cfg_i.ras_mode & {ebswc_pkg::ATTR_N{!FAST_ROW}};

  always_comb
  begin
    logic active;
    logic sel;
    active = 1'b0;
    sel = 1'b0;
    next_r = r;
    next_r.ack_meta = transfer_ack_n_i;
    next_r.ack_sync = r.ack_meta;
    next_r.done = 1'b0;
    case (r.state)
      ebswc_pkg::ST_IDLE:
      begin
        if (take)
        begin
          next_r.state = ebswc_pkg::ST_ACCESS;
          next_r.cnt = req_i.waits;
          next_r.waits = req_i.waits;
          next_r.write = req_i.write;
          next_r.prio_off = cfg_i.prio_off;
          if (cfg_i.prio_off)
          begin
            next_r.attr_act = req_i.attr;
          end
          else
          begin
            next_r.attr_act = prio_pick(req_i.attr);
          end
        end
      end
      ebswc_pkg::ST_ACCESS:
      begin
        // Losing the bus mid-cycle abandons the access without a done.
        if (!link_ok)
        begin
          next_r.state = ebswc_pkg::ST_IDLE;
        end
        else if (r.cnt != '0)
        begin
          next_r.cnt = r.cnt - 1'b1;
        end
        else if (r.waits == '0)
        begin
          next_r.state = ebswc_pkg::ST_IDLE;
          next_r.done = 1'b1;
        end
        else if (ack_on)
        begin
          next_r.state = ebswc_pkg::ST_IDLE;
          next_r.done = 1'b1;
        end
        // Otherwise the cycle is held for another wait state.
      end
      default:
      begin
        next_r.state = ebswc_pkg::ST_IDLE;
      end
    endcase
    active = (next_r.state == ebswc_pkg::ST_ACCESS);
    next_r.busy = active;
    next_r.rd_n = !(active && !next_r.write);
    next_r.wr_n = !(active && next_r.write);
    next_r.ctl_oe = link_ok;
    for (int i = 0; i < ebswc_pkg::ATTR_N; i++)
    begin
      sel = active && next_r.attr_act[i];
      // A low-active row strobe idles high; everything else idles low.
      if (eff_ras[i] && !cfg_i.ras_pol[i])
      begin
        next_r.line[i] = !sel;
      end
      else
      begin
        next_r.line[i] = sel;
      end
      next_r.line_oe[i] = link_ok;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= ebswc_pkg::REGS_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign access_busy_o = r.busy;
  assign cycle_done_ack_o = r.done;
  assign attr_select_line_o = r.line;
  assign attr_select_line_oe_o = r.line_oe;
  assign read_strobe_n_o = r.rd_n;
  assign read_strobe_oe_o = r.ctl_oe;
  assign write_strobe_n_o = r.wr_n;
  assign write_strobe_oe_o = r.ctl_oe;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic in_acc;
  logic at_end;
  assign in_acc = (r.state == ebswc_pkg::ST_ACCESS);
  assign at_end = in_acc && link_ok && (r.cnt == '0) && (r.waits != '0);

  property p_prio_onehot;
    in_acc && !r.prio_off |-> $onehot0(r.attr_act);
  endproperty
  a_prio_onehot: assert property (p_prio_onehot)
    else $error("More than one attribute line selected in priority mode.");

  property p_release;
    !link_ok |=> !read_strobe_oe_o && !write_strobe_oe_o
      && (attr_select_line_oe_o == '0) && !access_busy_o;
  endproperty
  a_release: assert property (p_release)
    else $error("Port outputs still driven without bus ownership.");

  property p_read_driven;
    !read_strobe_n_o |-> read_strobe_oe_o && write_strobe_n_o;
  endproperty
  a_read_driven: assert property (p_read_driven)
    else $error("Read strobe low while floated or with write strobe.");

  property p_write_driven;
    !write_strobe_n_o |-> write_strobe_oe_o && access_busy_o;
  endproperty
  a_write_driven: assert property (p_write_driven)
    else $error("Write strobe low while floated or idle.");

  sequence s_take_zero;
    take && (req_i.waits == '0) && !req_i.write;
  endsequence
  sequence s_one_strobe;
    !read_strobe_n_o ##1 (cycle_done_ack_o && read_strobe_n_o);
  endsequence
  property p_zero_wait;
    s_take_zero ##1 link_ok |-> s_one_strobe;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("Zero-wait read did not finish after one cycle.");

  property p_min_wait;
    in_acc && link_ok && (r.cnt != '0) |=> in_acc && !cycle_done_ack_o;
  endproperty
  a_min_wait: assert property (p_min_wait)
    else $error("Access ended before programmed waits ran out.");

  property p_ack_end;
    at_end && ack_on |=> cycle_done_ack_o && !access_busy_o
      && read_strobe_n_o && write_strobe_n_o;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("Access did not end one clock after acknowledge.");

  property p_ack_hold;
    at_end && !ack_on |=> access_busy_o && !cycle_done_ack_o;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("Access ended without acknowledge.");

  property p_done_cause;
    cycle_done_ack_o |-> $past(in_acc) && !$past(take);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("Done pulse without an access in progress.");

  property p_sync_delay;
    eff_sync && $stable(eff_sync) && !$past(transfer_ack_n_i, 2)
      |-> ack_on;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Synchronised acknowledge not seen two clocks later.");

  property p_no_fast_row;
    FAST_ROW |-> (eff_ras == '0);
  endproperty
  a_no_fast_row: assert property (p_no_fast_row)
    else $error("Row strobe mode active above the supported rate.");

  sequence s_read_on;
    !read_strobe_n_o && write_strobe_n_o && access_busy_o;
  endsequence
  sequence s_write_on;
    !write_strobe_n_o && read_strobe_n_o && access_busy_o;
  endsequence

  property p_take_read;
    take && !req_i.write |=> s_read_on;
  endproperty
  a_take_read: assert property (p_take_read)
    else $error("Read strobe not low after a read was taken.");

  property p_take_write;
    take && req_i.write |=> s_write_on;
  endproperty
  a_take_write: assert property (p_take_write)
    else $error("Write strobe not low after a write was taken.");

  property p_done_pulse;
    cycle_done_ack_o |=> !cycle_done_ack_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("Done pulse lasted more than one clock.");

  property p_prio_pass;
    take && cfg_i.prio_off |=> r.attr_act == $past(req_i.attr);
  endproperty
  a_prio_pass: assert property (p_prio_pass)
    else $error("Attribute code altered with priority disabled.");

  // Idle level of each pin: row strobes rest at their inactive level.
  logic [ebswc_pkg::ATTR_N-1:0] idle_lvl;
  assign idle_lvl = eff_ras & ~cfg_i.ras_pol;

  property p_idle_lines;
    !in_acc && !take |=> attr_select_line_o == $past(idle_lvl);
  endproperty
  a_idle_lines: assert property (p_idle_lines)
    else $error("Idle attribute or row strobe level is wrong.");

endmodule

// ==== dv/ebswc_mem_model.sv ====
/*
  Wait-state partner: holds transfer acknowledge inactive, lowers it a
  set number of edges into a strobe and releases it once the strobe ends.
  Assumes one clock shared with ebswc_core.
*/
`timescale 1ns/1ps
module ebswc_mem_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Strobe activity and acknowledge timing
  input wire logic strobe_act_i,
  input wire logic [7:0] ack_edge_i,
  // Acknowledge pin
  output logic transfer_ack_n_o
);
  logic [7:0] cnt;

  // A zero edge count acknowledges only on the 256th edge, once cnt wraps, which models a very slow memory.
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 8'h00;
      transfer_ack_n_o <= 1'b1;
    end
    else if (!strobe_act_i)
    begin
      cnt <= 8'h00;
      transfer_ack_n_o <= #1 1'b1;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      if (cnt + 8'h01 == ack_edge_i)
        transfer_ack_n_o <= #1 1'b0;
    end
  end
endmodule

// ==== dv/ebswc_bench.sv ====
/*
  Self-checking bench for ebswc_core: strobes, priority, wait states,
  acknowledge stretching and forced release. Assumes the default
  200 MHz build, so sampling is synchronised and row strobes are off;
  a second build at the direct-sampling limit shares all inputs and
  covers direct acknowledge sampling and row strobes.
*/
`timescale 1ns/1ps
module ebswc_bench;
  logic clk_sys_i, rst_i, owner, standby, req_valid, done, busy, ack_n;
  logic rd_n, rd_oe, wr_n, wr_oe, act, done2;
  logic [ebswc_pkg::ATTR_N-1:0] line, line_oe, l1, line2, l2;
  logic [7:0] ack_edge;
  ebswc_pkg::ebswc_cfg_t cfg;
  ebswc_pkg::ebswc_req_t req;
  int mismatches, comparisons, e, e2;

  assign act = (!rd_n && rd_oe) || (!wr_n && wr_oe);

  ebswc_core dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .bus_owner_i(owner), .standby_i(standby), .cfg_i(cfg),
    .req_valid_i(req_valid), .req_i(req), .access_busy_o(busy),
    .cycle_done_ack_o(done), .transfer_ack_n_i(ack_n),
    .attr_select_line_o(line), .attr_select_line_oe_o(line_oe),
    .read_strobe_n_o(rd_n), .read_strobe_oe_o(rd_oe),
    .write_strobe_n_o(wr_n), .write_strobe_oe_o(wr_oe));

  ebswc_mem_model mem_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .strobe_act_i(act), .ack_edge_i(ack_edge), .transfer_ack_n_o(ack_n));

  // The partner follows dut_u only; this copy just listens to its answer.
  ebswc_core #(.CLK_MHZ(ebswc_pkg::ACK_DIRECT_MAX_MHZ)) dut_slow_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .bus_owner_i(owner), .standby_i(standby), .cfg_i(cfg),
    .req_valid_i(req_valid), .req_i(req), .access_busy_o(),
    .cycle_done_ack_o(done2), .transfer_ack_n_i(ack_n),
    .attr_select_line_o(line2), .attr_select_line_oe_o(),
    .read_strobe_n_o(), .read_strobe_oe_o(),
    .write_strobe_n_o(), .write_strobe_oe_o());

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic edge1();
    @(posedge clk_sys_i);
    #1;
  endtask

  // A gap first lets a stale synchronised acknowledge drain away.
  task automatic run(input logic w, input logic [3:0] a,
    input logic [4:0] n, input logic [7:0] k);
    repeat (4) edge1();
    ack_edge = k;
    req = '{write: w, attr: a, waits: n};
    req_valid = 1'b1;
    edge1();
    req_valid = 1'b0;
    l1 = line;
    l2 = line2;
    chk(w ? (wr_n === 1'b0 && rd_n === 1'b1 && wr_oe === 1'b1)
      : (rd_n === 1'b0 && wr_n === 1'b1 && rd_oe === 1'b1), "strobe");
    e = 0;
    e2 = -1;
    while (done !== 1'b1)
    begin
      edge1();
      e++;
      if (done2 === 1'b1)
        e2 = e;
      if (e > 100)
      begin
        mismatches++;
        test_done();
      end
    end
  endtask

  initial
  begin
    rst_i = 1'b1;
    owner = 1'b1;
    standby = 1'b0;
    req_valid = 1'b0;
    cfg = '0;
    req = '0;
    ack_edge = 8'h00;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    edge1();
    for (int p = 0; p < 2; p++)
      for (int a = 1; a < 16; a++)
      begin
        cfg.prio_off = p[0];
        run(a[0], a[3:0], 5'h00, 8'h00);
        chk(e === 1, "zero wait");
        chk(l1 === (p[0] ? a[3:0] : a[0] ? 4'h1 : a[1] ? 4'h2
          : a[2] ? 4'h4 : 4'h8), "attr");
      end
    cfg.prio_off = 1'b0;
    run(1'b0, 4'h6, 5'h02, 8'h02);
    chk(e === 5, "wait two");
    chk(e2 === 3, "direct ack");
    chk(l1 === 4'h2, "prio");
    cfg.ack_sync = 1'b1;
    run(1'b0, 4'h1, 5'h01, 8'h14);
    chk(e === 23, "long stretch");
    chk(e2 === 23, "sync select");
    cfg.ras_mode = 4'hF;
    cfg.ras_pol = 4'h1;
    run(1'b1, 4'h8, 5'h05, 8'h01);
    chk(e === 6, "wait five");
    chk(l1 === 4'h8, "no row strobe");
    chk(l2 === 4'h6, "row strobe");
    owner = 1'b0;
    req_valid = 1'b1;
    repeat (3) edge1();
    chk({busy, rd_oe, wr_oe, line_oe} === 7'h00, "not owner");
    req_valid = 1'b0;
    owner = 1'b1;
    edge1();
    req = '{write: 1'b0, attr: 4'h2, waits: 5'h03};
    req_valid = 1'b1;
    edge1();
    req_valid = 1'b0;
    standby = 1'b1;
    edge1();
    chk({busy, done, rd_oe, wr_oe, line_oe} === 8'h00, "standby");
    test_done();
  end
endmodule
